// file: src/istm_cfg.svh
// per-cycle state figures and phase indices for the execution-state sequencer
// assumes: included by the sequencer by bare name
`ifndef ISTM_CFG_SVH
`define ISTM_CFG_SVH

// ----------------------------------------
// states per cycle type
// ----------------------------------------
`define ISTM_FETCH_STATES 2'h2
`define ISTM_BADDR_STATES 2'h2
`define ISTM_STACK_STATES 2'h2
`define ISTM_BYTE_MEM_STATES 2'h2
`define ISTM_BYTE_PERI_FAST 2'h2
`define ISTM_BYTE_PERI_SLOW 2'h3
`define ISTM_WORD_STATES 2'h2
`define ISTM_INTOP_STATES 2'h1

// ----------------------------------------
// phase indices, in the order they run
// ----------------------------------------
`define ISTM_PH_FETCH 0
`define ISTM_PH_BADDR 1
`define ISTM_PH_STACK 2
`define ISTM_PH_BYTE 3
`define ISTM_PH_WORD 4
`define ISTM_PH_INTOP 5
`define ISTM_NUM_PH 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define ISTM_TOTAL_RST 5'h00
`define ISTM_CNT_RST 2'h0

`endif

// file: src/istm_pkg.sv
// types for the execution-state sequencer
// assumes: istm_cfg.svh holds the figures
package istm_pkg;

    // ----------------------------------------
    // instruction forms covered
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_ADD_B_IMM  = 5'h00, // byte add, 8-bit immediate
        OP_ADD_B_REG  = 5'h01, // byte add, register
        OP_ADD_W_IMM  = 5'h02, // word add, 16-bit immediate
        OP_ADD_W_REG  = 5'h03, // word add, register
        OP_ADD_L_IMM  = 5'h04, // long add, 32-bit immediate
        OP_ADD_L_REG  = 5'h05, // long add, long_src_reg to long_dest_reg
        OP_ADD_SMALL  = 5'h06, // add_small_const_to_addr_reg
        OP_ADDC_IMM   = 5'h07, // add_with_carry, immediate
        OP_ADDC_REG   = 5'h08, // add_with_carry, register
        OP_AND_B_IMM  = 5'h09, // byte and, immediate
        OP_AND_B_REG  = 5'h0a, // byte and, register
        OP_AND_W_IMM  = 5'h0b, // word and, immediate
        OP_AND_W_REG  = 5'h0c, // word and, register
        OP_AND_L_IMM  = 5'h0d, // long and, immediate
        OP_AND_L_REG  = 5'h0e, // long and, register pair
        OP_AND_FLAGS  = 5'h0f, // and_into_flags on condition_code_reg
        OP_BAND_REG   = 5'h10, // bit-and into carry, register
        OP_BAND_IND   = 5'h11, // bit-and into carry, indirect
        OP_BAND_ABS   = 5'h12, // bit-and into carry, 8-bit absolute
        OP_BR_D8      = 5'h13, // branch, 8-bit displacement
        OP_BR_D16     = 5'h14, // branch, 16-bit displacement
        OP_CALL_VEC   = 5'h15, // subroutine_call via memory vector
        OP_BIT_SET_OP_ABS   = 5'h16  // bit_set_op at absolute address
    } istm_op_e;

    // ----------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01, // waiting for an instruction
        ST_FETCH = 7'h02, // instruction fetch cycle
        ST_BADDR = 7'h04, // branch address read cycle
        ST_STACK = 7'h08, // stack cycle
        ST_BYTE  = 7'h10, // byte data access cycle
        ST_WORD  = 7'h20, // word data access cycle
        ST_INTOP = 7'h40  // internal operation cycle
    } istm_state_e;

endpackage : istm_pkg

// file: src/istm_seq.sv
// execution-state sequencer: walks the cycle types of one instruction
// assumes: one clock, inputs synchronous, start only counts while idle
`include "istm_cfg.svh"

module istm_seq (
    input wire logic clock, // 25 mhz core clock
    input wire logic rst, // synchronous reset, active high
    input wire logic start, // request to time one instruction
    input wire logic [4:0] op_class, // instruction form code
    input wire logic byte_periph, // byte access targets a peripheral
    input wire logic periph_slow, // addressed peripheral needs three states
    output logic busy, // instruction in progress
    output logic [5:0] cycle_type, // one-hot current cycle type
    output logic done, // one-cycle pulse after last state
    output logic rejected, // one-cycle pulse, unknown form refused
    output logic [4:0] total_states // states of last finished instruction
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    istm_pkg::istm_state_e state_q, state_d; // current cycle type
    logic [1:0] rem_q [`ISTM_NUM_PH]; // cycles left per type
    logic [1:0] st_q; // state within current cycle
    logic [1:0] byte_len_q; // states per byte cycle, latched
    logic [4:0] tot_q; // states so far
    logic [4:0] total_q; // result register
    logic done_q; // finish pulse
    logic rej_q; // refuse pulse
    logic busy_q; // busy flag
    logic [4:0] exp_q; // expected total, for checking only

    // ----------------------------------------
    // cycle count lookup {n,m,l,k,j,i}
    // ----------------------------------------
    function automatic logic [11:0] mk(input logic [1:0] i, input logic [1:0] j,
                                        input logic [1:0] k, input logic [1:0] l,
                                        input logic [1:0] m, input logic [1:0] n);
        mk = {n, m, l, k, j, i};
    endfunction

    function automatic logic [12:0] lut(input logic [4:0] code);
        logic [12:0] r; // bit 12 = known form
        r = {1'b1, 12'h000};
        unique case (istm_pkg::istm_op_e'(code))
            istm_pkg::OP_ADD_B_IMM,
            istm_pkg::OP_ADD_B_REG: r[11:0] = mk(2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_ADD_W_IMM: r[11:0] = mk(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_ADD_W_REG: r[11:0] = mk(2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_ADD_L_IMM: r[11:0] = mk(2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_ADD_L_REG: r[11:0] = mk(2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_ADD_SMALL,
            istm_pkg::OP_ADDC_IMM,
            istm_pkg::OP_ADDC_REG,
            istm_pkg::OP_AND_FLAGS: r[11:0] = mk(2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_AND_B_IMM,
            istm_pkg::OP_AND_B_REG,
            istm_pkg::OP_AND_W_REG: r[11:0] = mk(2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_AND_W_IMM: r[11:0] = mk(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_AND_L_IMM: r[11:0] = mk(2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_AND_L_REG: r[11:0] = mk(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_BAND_REG:  r[11:0] = mk(2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_BAND_IND,
            istm_pkg::OP_BAND_ABS:  r[11:0] = mk(2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0);
            istm_pkg::OP_BR_D8:     r[11:0] = mk(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_BR_D16:    r[11:0] = mk(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2);
            istm_pkg::OP_CALL_VEC:  r[11:0] = mk(2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0);
            istm_pkg::OP_BIT_SET_OP_ABS:  r[11:0] = mk(2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0);
            default: r = 13'h0000; // codes past the table are refused
        endcase
        return r;
    endfunction

    // first type at or after 'from' with cycles left, else idle
    function automatic logic [6:0] first_ph(input logic [11:0] c, input int from);
        logic [6:0] r;
        r = istm_pkg::ST_IDLE;
        for (int p = `ISTM_NUM_PH - 1; p >= from; p--) begin
            if (c[2*p +: 2] != 2'h0) begin
                r = 7'h01 << (p + 1); // zero-count types are skipped
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // decode and per-cycle lengths
    // ----------------------------------------
    wire logic [12:0] lut_w = lut(op_class); // lookup for request
    wire logic is_idle = (state_q == istm_pkg::ST_IDLE); // ready for request
    wire logic take = start && is_idle && lut_w[12]; // request accepted
    wire logic refuse = start && is_idle && !lut_w[12]; // unknown form
    wire logic [1:0] byte_len_w = !byte_periph ? `ISTM_BYTE_MEM_STATES :
        (periph_slow ? `ISTM_BYTE_PERI_SLOW : `ISTM_BYTE_PERI_FAST);
    wire logic [11:0] rem_flat = {rem_q[5], rem_q[4], rem_q[3], rem_q[2], rem_q[1], rem_q[0]};
    logic [1:0] cyc_len; // states per cycle of current type
    always_comb begin
        cyc_len = 2'h1; // idle value, also covers an unsettled state before reset
        unique case (state_q)
            istm_pkg::ST_FETCH: cyc_len = `ISTM_FETCH_STATES;
            istm_pkg::ST_BADDR: cyc_len = `ISTM_BADDR_STATES;
            istm_pkg::ST_STACK: cyc_len = `ISTM_STACK_STATES;
            istm_pkg::ST_BYTE:  cyc_len = byte_len_q;
            istm_pkg::ST_WORD:  cyc_len = `ISTM_WORD_STATES;
            istm_pkg::ST_INTOP: cyc_len = `ISTM_INTOP_STATES;
            istm_pkg::ST_IDLE:  cyc_len = 2'h1;
        endcase
    end
    wire logic cyc_end = !is_idle && (st_q == cyc_len - 2'h1); // last state of a cycle
    logic [2:0] cur_idx; // index of current type
    always_comb begin
        cur_idx = 3'h0;
        for (int p = 0; p < `ISTM_NUM_PH; p++) begin
            if (state_q[p + 1]) begin
                cur_idx = 3'(p);
            end
        end
    end
    wire logic last_of_type = cyc_end && (rem_q[cur_idx] == 2'h1); // type exhausted
    // next type only after this one ends, so cycles never overlap
    always_comb begin
        state_d = state_q;
        if (take) begin
            state_d = istm_pkg::istm_state_e'(first_ph(lut_w[11:0], 0));
        end else if (last_of_type) begin
            state_d = istm_pkg::istm_state_e'(first_ph(rem_flat, int'(cur_idx) + 1));
        end
    end
    wire logic finish = last_of_type && (state_d == istm_pkg::ST_IDLE); // last state now

    // ----------------------------------------
    // remaining-cycle counters, one per type
    // ----------------------------------------
    for (genvar g = 0; g < `ISTM_NUM_PH; g++) begin : g_rem
        always_ff @(posedge clock) begin
            if (rst) begin
                rem_q[g] <= `ISTM_CNT_RST;
            end else if (take) begin
                rem_q[g] <= lut_w[2*g +: 2];
            end else if (cyc_end && state_q[g + 1]) begin
                rem_q[g] <= rem_q[g] - 2'h1;
            end
        end
    end

    // ----------------------------------------
    // state, within-cycle and total counters
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= istm_pkg::ST_IDLE;
            st_q <= 2'h0;
            byte_len_q <= `ISTM_BYTE_MEM_STATES;
            tot_q <= `ISTM_TOTAL_RST;
        end else begin
            state_q <= state_d;
            st_q <= (take || cyc_end) ? 2'h0 : st_q + 2'h1;
            // byte length is fixed for the whole instruction
            byte_len_q <= take ? byte_len_w : byte_len_q;
            tot_q <= take ? 5'h00 : (is_idle ? tot_q : tot_q + 5'h01);
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rej_q <= 1'b0;
            total_q <= `ISTM_TOTAL_RST;
        end else begin
            busy_q <= (state_d != istm_pkg::ST_IDLE);
            done_q <= finish;
            rej_q <= refuse;
            total_q <= finish ? tot_q + 5'h01 : total_q;
        end
    end
    assign busy = busy_q;
    assign cycle_type = state_q[6:1];
    assign done = done_q;
    assign rejected = rej_q;
    assign total_states = total_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // expected total from the weighted sum, latched at acceptance
    wire logic [4:0] exp_w = 5'(lut_w[1:0] * `ISTM_FETCH_STATES)
        + 5'(lut_w[3:2] * `ISTM_BADDR_STATES) + 5'(lut_w[5:4] * `ISTM_STACK_STATES)
        + 5'(lut_w[7:6] * byte_len_w) + 5'(lut_w[9:8] * `ISTM_WORD_STATES)
        + 5'(lut_w[11:10] * `ISTM_INTOP_STATES);
    always_ff @(posedge clock) begin
        if (rst) begin
            exp_q <= 5'h00;
        end else if (take) begin
            exp_q <= exp_w;
        end
    end
    wire logic ph_f = (state_q == istm_pkg::ST_FETCH); // in fetch
    wire logic ph_b = (state_q == istm_pkg::ST_BYTE); // in byte access
    wire logic ph_n = (state_q == istm_pkg::ST_INTOP); // in internal op
    wire logic mem_take = take && !byte_periph; // on-chip memory operands

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    total_sum_a: assert property (done_q |-> total_q == exp_q)
        else $error("total states differ from weighted sum");
    fetch_two_a: assert property ($rose(ph_f) |-> ph_f[*2])
        else $error("fetch cycle shorter than two states");
    byte_len_a: assert property (ph_b |-> st_q < byte_len_q && byte_len_q >= 2'h2)
        else $error("byte access state count out of range");
    intop_one_a: assert property (ph_n |-> st_q == 2'h0)
        else $error("internal operation longer than one state");
    add_byte_a: assert property (take && op_class == istm_pkg::OP_ADD_B_IMM
        |=> ph_f[*2] ##1 done_q)
        else $error("byte add not a single fetch");
    add_word_a: assert property (take && op_class == istm_pkg::OP_ADD_W_IMM
        |=> ph_f[*4] ##1 done_q)
        else $error("word immediate add not two fetches");
    add_long_a: assert property (take && op_class == istm_pkg::OP_ADD_L_IMM
        |=> ph_f[*6] ##1 done_q)
        else $error("long immediate add not three fetches");
    and_long_a: assert property (take && op_class == istm_pkg::OP_AND_L_REG
        |=> ph_f[*4] ##1 done_q)
        else $error("long register and not two fetches");
    flag_and_a: assert property (take && op_class == istm_pkg::OP_AND_FLAGS
        |=> ph_f[*2] ##1 done_q)
        else $error("flag and not a single fetch");
    bit_and_a: assert property (mem_take && op_class == istm_pkg::OP_BAND_ABS
        |=> ph_f[*4] ##1 ph_b[*2] ##1 done_q)
        else $error("memory bit-and sequence wrong");
    short_br_a: assert property (take && op_class == istm_pkg::OP_BR_D8
        |=> (!ph_n)[*4] ##1 done_q)
        else $error("short branch used internal cycles");
    call_vec_a: assert property (take && op_class == istm_pkg::OP_CALL_VEC
        |=> ph_f[*4] ##1 (state_q == istm_pkg::ST_BADDR)[*2]
        ##1 (state_q == istm_pkg::ST_STACK)[*2] ##1 done_q)
        else $error("vector call sequence wrong");
    bit_set_a: assert property (mem_take && op_class == istm_pkg::OP_BIT_SET_OP_ABS
        |=> ph_f[*4] ##1 ph_b[*4] ##1 done_q)
        else $error("absolute bit set sequence wrong");
    one_type_a: assert property ($onehot(state_q))
        else $error("cycle types overlap");
    long_br_a: assert property (take && op_class == istm_pkg::OP_BR_D16
        |=> ph_f[*4] ##1 ph_n[*2] ##1 done_q)
        else $error("long branch sequence wrong");

    slow_byte_c: cover property (take && byte_periph && periph_slow
        && op_class == istm_pkg::OP_BIT_SET_OP_ABS ##11 done_q);
    call_c: cover property (take && op_class == istm_pkg::OP_CALL_VEC);
    back_to_back_c: cover property (done_q && take);
    refuse_c: cover property (rej_q);

endmodule // istm_seq

// file: testbench/istm_periph_model.sv
// on-chip memory and peripheral side: says how long a byte access lasts
// assumes: driven by the bench at the falling edge, read by the sequencer with start
module istm_periph_model #(
    parameter logic [7:0] SLOW_MASK = 8'ha5 // peripherals needing three states, plain default
) (
    input wire logic to_periph, // byte accesses go to a peripheral
    input wire logic [2:0] periph_idx, // which peripheral is addressed
    output logic byte_periph, // peripheral selected
    output logic periph_slow // selected peripheral takes three states
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // byte access length per addressed module
    // ----------------------------------------
    // with no peripheral selected the slow line carries the inverse of periph_idx[0], not a settled 0
    assign byte_periph = to_periph;
    assign periph_slow = to_periph ? SLOW_MASK[periph_idx] : ~periph_idx[0];
endmodule // istm_periph_model

// file: testbench/istm_seq_test.sv
// self-checking bench for the execution-state sequencer
// assumes: istm_seq and istm_periph_model compiled first, one 25 mhz clock
module istm_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SLOW_MASK = 8'ha5; // peripherals 0,2,5,7 are slow
    logic clock = 1'b0; // core clock
    logic rst = 1'b1; // synchronous reset
    logic start = 1'b0; // timing request
    logic [4:0] op_class = 5'h00; // instruction form
    logic to_periph = 1'b0; // byte accesses to a peripheral
    logic [2:0] periph_idx = 3'h0; // addressed peripheral
    logic byte_periph, periph_slow, busy, done, rejected; // model and design outputs
    logic [5:0] cycle_type; // current cycle type
    logic [4:0] total_states; // last total
    logic [15:0] lfsr_q = 16'h7559; // random source, seed 30041
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    istm_periph_model #(.SLOW_MASK(SLOW_MASK)) periph_u (.to_periph(to_periph),
        .periph_idx(periph_idx), .byte_periph(byte_periph), .periph_slow(periph_slow));
    istm_seq dut_u (.clock(clock), .rst(rst), .start(start), .op_class(op_class),
        .byte_periph(byte_periph), .periph_slow(periph_slow), .busy(busy),
        .cycle_type(cycle_type), .done(done), .rejected(rejected), .total_states(total_states));

    always #20 clock = ~clock;

    // ----------------------------------------
    // expectations
    // ----------------------------------------
    // packed counts {fetch, branch read, stack, byte, word, internal}, two bits each
    function automatic logic [11:0] counts(input logic [4:0] op);
        case (op)
            5'h02, 5'h0b, 5'h13: return 12'h800;
            5'h0e: return 12'h800;
            5'h04, 5'h0d: return 12'hc00;
            5'h11, 5'h12: return 12'h810;
            5'h14: return 12'h802;
            5'h15: return 12'h940;
            5'h16: return 12'h820;
            default: return 12'h400;
        endcase
    endfunction
    // states per cycle: fetch 2, byte by location, internal 1
    function automatic int wt(input int t, input int bs);
        return (t == 3) ? bs : ((t == 5) ? 1 : 2);
    endfunction
    // which cycle type the k-th state belongs to, 6 past the end; tot gives the total
    function automatic int walk(input logic [11:0] c, input int k, input int bs, output int tot);
        int n;
        tot = 0;
        walk = 6;
        for (int t = 0; t < 6; t++) begin
            n = int'(c[11-2*t -: 2]) * wt(t, bs);
            if (walk == 6 && k < tot + n) walk = t;
            tot += n;
        end
    endfunction

    // ----------------------------------------
    // compare tasks and stimulus
    // ----------------------------------------
    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_type(input logic [5:0] got, input logic [5:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t cycle type got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_total(input logic [4:0] got, input logic [4:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t total got %h expected %h", $time, got, exp);
        end
    endtask
    // next value of the 16-bit random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic step_lfsr();
        lfsr_q = lfsr_next(lfsr_q);
    endtask
    // offer one form at a falling edge; noisy keeps poking the inputs while busy
    task automatic run_op(input logic [4:0] op, input logic tp, input logic [2:0] pi,
                          input logic noisy);
        int t, k, ty, bs;
        logic [11:0] c;
        c = counts(op);
        bs = (tp && SLOW_MASK[pi]) ? 3 : 2;
        ty = walk(c, 0, bs, t);
        op_class = op;
        to_periph = tp;
        periph_idx = pi;
        start = 1'b1;
        @(negedge clock);
        for (k = 0; k < t; k++) begin
            ty = walk(c, k, bs, t);
            check_type(cycle_type, 6'h01 << ty);
            check_bit(busy, 1'b1);
            check_bit(done, 1'b0);
            // requests while busy must be ignored; start is quiet in the last state
            // so it is low before the done cycle, with one write per edge
            start = noisy && lfsr_q[0] && (k < t - 1);
            if (noisy) begin
                op_class = lfsr_q[5:1];
                to_periph = lfsr_q[6];
                periph_idx = lfsr_q[9:7];
                step_lfsr();
            end
            @(negedge clock);
        end
        check_bit(done, 1'b1);
        check_bit(busy, 1'b0);
        check_total(total_states, t[4:0]);
        check_type(cycle_type, 6'h00);
        check_bit(rejected, 1'b0);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic report_and_stop();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, generous against the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        repeat (6) @(negedge clock);
        check_type(cycle_type, 6'h00);
        check_total(total_states, 5'h00);
        rst = 1'b0;
        run_op(5'h16, 1'b0, 3'h1, 1'b0);
        run_op(5'h16, 1'b1, 3'h0, 1'b1);
        run_op(5'h16, 1'b1, 3'h1, 1'b0);
        run_op(5'h15, 1'b0, 3'h2, 1'b1);
        run_op(5'h14, 1'b1, 3'h0, 1'b0);
        run_op(5'h13, 1'b0, 3'h0, 1'b1);
        run_op(5'h0e, 1'b0, 3'h0, 1'b0);
        run_op(5'h11, 1'b1, 3'h7, 1'b1);
        run_op(5'h12, 1'b0, 3'h0, 1'b0);
        run_op(5'h04, 1'b0, 3'h0, 1'b0);
        // unknown form while idle is refused with a single pulse
        op_class = 5'h1f;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        check_bit(rejected, 1'b1);
        check_type(cycle_type, 6'h00);
        @(negedge clock);
        check_bit(rejected, 1'b0);
        // every form, random location, some with an idle gap
        for (int i = 0; i < 69; i++) begin
            run_op(5'(i % 23), lfsr_q[3], lfsr_q[6:4], lfsr_q[7]);
            step_lfsr();
            if (lfsr_q[0]) @(negedge clock);
        end
        // reset in mid-instruction abandons it
        op_class = 5'h15;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        rst = 1'b1;
        @(negedge clock);
        check_bit(busy, 1'b0);
        check_type(cycle_type, 6'h00);
        rst = 1'b0;
        run_op(5'h14, 1'b0, 3'h0, 1'b0);
        report_and_stop();
    end
endmodule // istm_seq_test
